// ### perf_status_pkg.sv
// shared constants for the line performance status message builder
package perf_status_pkg;
	localparam int MSG_OCTETS = 12;
	localparam logic [7:0] MSG_ID_NET  = 8'h8C;
	localparam logic [7:0] MSG_ID_CUST = 8'h8D;
	// wishbone byte addresses
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_SIDE_NET  = 8'h04;
	localparam logic [7:0] ADDR_SIDE_CUST = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;
	localparam logic [7:0] ADDR_FLAGS     = 8'h14;
	localparam logic [7:0] ADDR_CNT_NET   = 8'h18;
	localparam logic [7:0] ADDR_CRC_NET   = 8'h1C;
	localparam logic [7:0] ADDR_CNT_CUST  = 8'h20;
	localparam logic [7:0] ADDR_CRC_CUST  = 8'h24;
	// control register fields
	localparam int CTRL_SEND      = 0;
	localparam int CTRL_SIDE      = 1;
	localparam int CTRL_DEST      = 2;
	localparam int CTRL_CLR_NET   = 8;
	localparam int CTRL_CLR_CUST  = 9;
	localparam int CTRL_BUSY      = 16;
	// side register fields
	localparam int SIDE_MARGIN_LSB = 0;
	localparam int SIDE_ATTEN_LSB  = 8;
	localparam int SIDE_BASE_LSB   = 16;
	localparam int SIDE_EXT        = 20;
	localparam int SIDE_BACKOFF    = 21;
	localparam int SIDE_MARGIN_AL  = 22;
	localparam int SIDE_ATTEN_AL   = 23;
	localparam int SIDE_SYNC_AL    = 24;
	localparam int SIDE_LOOP_LSB   = 25;
	localparam logic [7:0] MARGIN_NOT_AVAILABLE = 8'h7F;
	localparam logic [7:0] ATTEN_NOT_AVAILABLE  = 8'h80;
	localparam logic [1:0] LOOP_ID_RESET        = 2'h1;
	localparam logic [31:0] SIDE_RESET = {5'h00, LOOP_ID_RESET, 9'h000, ATTEN_NOT_AVAILABLE,
		MARGIN_NOT_AVAILABLE};
	// interrupt status bits
	localparam int IRQ_SENT      = 0;
	localparam int IRQ_WRAP_NET  = 1;
	localparam int IRQ_WRAP_CUST = 2;
	localparam int IRQ_BITS      = 3;
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_SEND = 2'b01,
		SER_DONE = 2'b11
	} ser_state_e;
endpackage

// ### side_counters.sv
// modulo performance counters and sticky overflow/reset flags for one side
`timescale 1ns/1ps
module side_counters
	import perf_status_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	// one-cycle events from the line logic
	input  wire logic        errsec_tick,
	input  wire logic        sevsec_tick,
	input  wire logic        crc_tick,
	input  wire logic        syncloss_tick,
	input  wire logic        unavsec_tick,
	// control
	input  wire logic        clear_counts,
	input  wire logic        load,
	input  wire logic        clr_line,
	input  wire logic        clr_cust,
	// state
	output logic      [7:0]  errsec,
	output logic      [7:0]  sevsec,
	output logic      [15:0] crc_count,
	output logic      [7:0]  syncloss,
	output logic      [7:0]  unavsec,
	output logic      [3:0]  flags,
	output logic             wrapped
);
	// flags = {ovf_line, rst_line, ovf_cust, rst_cust}; new_* remember events since the snapshot
	logic [7:0]  next_errsec, next_sevsec, next_syncloss, next_unavsec;
	logic [15:0] next_crc;
	logic [3:0]  next_flags;
	logic        new_ovf, new_rst, next_new_ovf, next_new_rst;

	always_comb begin
		next_errsec   = errsec + {7'h00, errsec_tick};
		next_sevsec   = sevsec + {7'h00, sevsec_tick};
		next_crc      = crc_count + {15'h0000, crc_tick};
		next_syncloss = syncloss + {7'h00, syncloss_tick};
		next_unavsec  = unavsec + {7'h00, unavsec_tick};
		wrapped = !clear_counts && ((errsec_tick && errsec == 8'hFF) || (sevsec_tick && sevsec == 8'hFF) ||
			(crc_tick && crc_count == 16'hFFFF) || (syncloss_tick && syncloss == 8'hFF) ||
			(unavsec_tick && unavsec == 8'hFF));
		if (clear_counts) begin
			next_errsec   = 8'h00;
			next_sevsec   = 8'h00;
			next_crc      = 16'h0000;
			next_syncloss = 8'h00;
			next_unavsec  = 8'h00;
		end
		// a flag cleared by a response survives if a new event came after the snapshot
		next_flags[3] = wrapped || (clr_line ? new_ovf : flags[3]);
		next_flags[2] = clear_counts || (clr_line ? new_rst : flags[2]);
		next_flags[1] = wrapped || (clr_cust ? new_ovf : flags[1]);
		next_flags[0] = clear_counts || (clr_cust ? new_rst : flags[0]);
		next_new_ovf  = wrapped || (new_ovf && !load);
		next_new_rst  = clear_counts || (new_rst && !load);
	end

	// counters reset at power-up, so both reset flags start set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			errsec    <= 8'h00;
			sevsec    <= 8'h00;
			crc_count <= 16'h0000;
			syncloss  <= 8'h00;
			unavsec   <= 8'h00;
			flags     <= 4'h5;
			new_ovf   <= 1'b0;
			new_rst   <= 1'b1;
		end else if (ce) begin
			errsec    <= next_errsec;
			sevsec    <= next_sevsec;
			crc_count <= next_crc;
			syncloss  <= next_syncloss;
			unavsec   <= next_unavsec;
			flags     <= next_flags;
			new_ovf   <= next_new_ovf;
			new_rst   <= next_new_rst;
		end
	end
endmodule

// ### octet_serializer.sv
// sends a captured message one octet at a time with valid/ready handshake
`timescale 1ns/1ps
module octet_serializer
	import perf_status_pkg::*;
#(
	parameter int OCTETS = MSG_OCTETS
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              ce,
	// message in, first octet in the top byte
	input  wire logic              start,
	input  wire logic [8*OCTETS-1:0] msg,
	output logic                   busy,
	output logic                   done,
	// octet stream out
	output logic                   octet_valid,
	output logic      [7:0]        octet_data,
	output logic                   octet_last,
	input  wire logic              octet_ready
);
	ser_state_e              state, next_state;
	logic [8*OCTETS-1:0]     shreg, next_shreg;
	logic [7:0]              remain, next_remain;
	logic                    next_valid, next_last, next_done;

	always_comb begin
		next_state  = state;
		next_shreg  = shreg;
		next_remain = remain;
		next_valid  = octet_valid;
		next_last   = octet_last;
		next_done   = 1'b0;
		case (state)
			SER_IDLE: begin
				if (start) begin
					next_state  = SER_SEND;
					next_shreg  = msg;
					next_remain = 8'(OCTETS - 1);
					next_valid  = 1'b1;
					next_last   = 1'b0;
				end
			end
			SER_SEND: begin
				if (octet_ready) begin
					if (octet_last) begin
						next_state = SER_DONE;
						next_valid = 1'b0;
						next_last  = 1'b0;
						next_done  = 1'b1;
					end else begin
						next_shreg  = {shreg[8*OCTETS-9:0], 8'h00};
						next_remain = remain - 8'h01;
						next_last   = (remain == 8'h01);
					end
				end
			end
			SER_DONE: next_state = SER_IDLE;
			default:  next_state = SER_IDLE;
		endcase
	end

	assign octet_data = shreg[8*OCTETS-1 -: 8];
	assign busy       = (state != SER_IDLE);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state       <= SER_IDLE;
			shreg       <= '0;
			remain      <= 8'h00;
			octet_valid <= 1'b0;
			octet_last  <= 1'b0;
			done        <= 1'b0;
		end else if (ce) begin
			state       <= next_state;
			shreg       <= next_shreg;
			remain      <= next_remain;
			octet_valid <= next_valid;
			octet_last  <= next_last;
			done        <= next_done;
		end
	end
endmodule

// ### line_performance_status_builder.sv
// performance status message builder with wishbone registers and interrupt
`timescale 1ns/1ps
module line_performance_status_builder
	import perf_status_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// fault pins, asynchronous
	input  wire logic        self_test_fault,
	input  wire logic        dc_continuity_fault,
	// per-side one-cycle events, index 0 network side, 1 customer side
	input  wire logic [1:0]  errsec_tick,
	input  wire logic [1:0]  sevsec_tick,
	input  wire logic [1:0]  crc_tick,
	input  wire logic [1:0]  syncloss_tick,
	input  wire logic [1:0]  unavsec_tick,
	// message octet stream
	output logic             octet_valid,
	output logic      [7:0]  octet_data,
	output logic             octet_last,
	input  wire logic        octet_ready,
	// interrupt
	output logic             irq
);
	// fault pin synchronisers
	logic [1:0] fault_meta, fault_sync;

	// registers
	logic [31:0]         side_cfg [2];
	logic [31:0]         next_side_cfg [2];
	logic [IRQ_BITS-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask;
	logic                sel_side, sel_dest, next_sel_side, next_sel_dest;
	logic [31:0]         next_dat;
	logic                next_ack, next_irq;

	// side state
	logic [7:0]  errsec [2];
	logic [7:0]  sevsec [2];
	logic [15:0] crc_count [2];
	logic [7:0]  syncloss [2];
	logic [7:0]  unavsec [2];
	logic [3:0]  flags [2];
	logic [1:0]  wrapped, clear_counts, load, clr_line, clr_cust;

	// message and serializer
	logic [8*MSG_OCTETS-1:0] msg;
	logic                    start, busy, done;
	logic                    ser_valid, ser_last;
	logic [7:0]              ser_data;
	logic                    wr, rd_hit;
	logic [31:0]             wmask;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fault_meta <= 2'h0;
			fault_sync <= 2'h0;
		end else if (ce) begin
			fault_meta <= {self_test_fault, dc_continuity_fault};
			fault_sync <= fault_meta;
		end
	end

	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : g_side
			side_counters u_cnt (
				.clk_sys       (clk_sys),
				.rst           (rst),
				.ce            (ce),
				.errsec_tick   (errsec_tick[s]),
				.sevsec_tick   (sevsec_tick[s]),
				.crc_tick      (crc_tick[s]),
				.syncloss_tick (syncloss_tick[s]),
				.unavsec_tick  (unavsec_tick[s]),
				.clear_counts  (clear_counts[s]),
				.load          (load[s]),
				.clr_line      (clr_line[s]),
				.clr_cust      (clr_cust[s]),
				.errsec        (errsec[s]),
				.sevsec        (sevsec[s]),
				.crc_count     (crc_count[s]),
				.syncloss      (syncloss[s]),
				.unavsec       (unavsec[s]),
				.flags         (flags[s]),
				.wrapped       (wrapped[s])
			);
			// flags clear only for the side that was sent, toward the unit that received it
			// the snapshot belongs to the side named by this send, whatever side went before
			assign load[s]     = start && (next_sel_side == 1'(s));
			assign clr_line[s] = done && (sel_side == 1'(s)) && !sel_dest;
			assign clr_cust[s] = done && (sel_side == 1'(s)) && sel_dest;
			assign clear_counts[s] = wr && wb_adr_i == ADDR_CTRL && wmask[CTRL_CLR_NET + s] &&
				wb_dat_i[CTRL_CLR_NET + s];
		end
	endgenerate

	// message assembly for the side picked at start
	always_comb begin
		logic [31:0] cfg;
		logic        side;
		cfg  = 32'h00000000;
		side = next_sel_side;
		cfg  = side_cfg[side];
		msg = {
			side ? MSG_ID_CUST : MSG_ID_NET,
			1'b0, cfg[SIDE_BACKOFF],
			fault_sync[1],
			fault_sync[0],
			cfg[SIDE_MARGIN_AL], cfg[SIDE_ATTEN_AL], cfg[SIDE_SYNC_AL], 1'b0,
			cfg[SIDE_MARGIN_LSB +: 8],
			cfg[SIDE_ATTEN_LSB +: 8],
			errsec[side], sevsec[side],
			crc_count[side],
			syncloss[side], unavsec[side],
			flags[side],
			cfg[SIDE_BASE_LSB +: 4],
			cfg[SIDE_EXT],
			5'h00, cfg[SIDE_LOOP_LSB +: 2]
		};
	end

	octet_serializer #(
		.OCTETS (MSG_OCTETS)
	) u_ser (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.ce          (ce),
		.start       (start),
		.msg         (msg),
		.busy        (busy),
		.done        (done),
		.octet_valid (ser_valid),
		.octet_data  (ser_data),
		.octet_last  (ser_last),
		.octet_ready (octet_ready)
	);

	assign octet_valid = ser_valid;
	assign octet_data  = ser_data;
	assign octet_last  = ser_last;

	// bus decode; every access is answered one cycle after the strobe
	assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// a send request while a message is in flight is dropped
	assign start = wr && wb_adr_i == ADDR_CTRL && wmask[CTRL_SEND] && wb_dat_i[CTRL_SEND] && !busy;
	assign rd_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_comb begin
		next_side_cfg = side_cfg;
		next_irq_mask = irq_mask;
		next_sel_side = sel_side;
		next_sel_dest = sel_dest;
		if (start) begin
			next_sel_side = wb_dat_i[CTRL_SIDE];
			next_sel_dest = wb_dat_i[CTRL_DEST];
		end
		if (wr && wb_adr_i == ADDR_SIDE_NET)
			next_side_cfg[0] = (side_cfg[0] & ~wmask) | (wb_dat_i & wmask);
		if (wr && wb_adr_i == ADDR_SIDE_CUST)
			next_side_cfg[1] = (side_cfg[1] & ~wmask) | (wb_dat_i & wmask);
		if (wr && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0])
			next_irq_mask = wb_dat_i[IRQ_BITS-1:0];
		// hardware set wins over the write-one clear in the same cycle
		next_irq_stat = irq_stat;
		if (wr && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0])
			next_irq_stat = irq_stat & ~wb_dat_i[IRQ_BITS-1:0];
		next_irq_stat[IRQ_SENT]      = next_irq_stat[IRQ_SENT] | done;
		next_irq_stat[IRQ_WRAP_NET]  = next_irq_stat[IRQ_WRAP_NET] | wrapped[0];
		next_irq_stat[IRQ_WRAP_CUST] = next_irq_stat[IRQ_WRAP_CUST] | wrapped[1];
		next_irq = |(next_irq_stat & next_irq_mask);
		next_ack = rd_hit;
		next_dat = 32'h00000000;
		if (rd_hit && !wb_we_i) begin
			case (wb_adr_i)
				ADDR_CTRL:      next_dat = {15'h0000, busy, 13'h0000, sel_dest, sel_side, 1'b0};
				ADDR_SIDE_NET:  next_dat = side_cfg[0];
				ADDR_SIDE_CUST: next_dat = side_cfg[1];
				ADDR_IRQ_STAT:  next_dat = {29'h00000000, irq_stat};
				ADDR_IRQ_MASK:  next_dat = {29'h00000000, irq_mask};
				ADDR_FLAGS:     next_dat = {24'h000000, flags[1], flags[0]};
				ADDR_CNT_NET:   next_dat = {unavsec[0], syncloss[0], sevsec[0], errsec[0]};
				ADDR_CRC_NET:   next_dat = {16'h0000, crc_count[0]};
				ADDR_CNT_CUST:  next_dat = {unavsec[1], syncloss[1], sevsec[1], errsec[1]};
				ADDR_CRC_CUST:  next_dat = {16'h0000, crc_count[1]};
				default:        next_dat = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			side_cfg[0] <= SIDE_RESET;
			side_cfg[1] <= SIDE_RESET;
			irq_stat    <= '0;
			irq_mask    <= '0;
			sel_side    <= 1'b0;
			sel_dest    <= 1'b0;
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= 32'h00000000;
			irq         <= 1'b0;
		end else if (ce) begin
			side_cfg    <= next_side_cfg;
			irq_stat    <= next_irq_stat;
			irq_mask    <= next_irq_mask;
			sel_side    <= next_sel_side;
			sel_dest    <= next_sel_dest;
			wb_ack_o    <= next_ack;
			wb_dat_o    <= next_dat;
			irq         <= next_irq;
		end
	end
endmodule

// ### line_performance_status_builder_properties.sv
// concurrent checks on the status octet stream and the register bus handshake
`timescale 1ns/1ps
module line_performance_status_builder_properties
	import perf_status_pkg::*;
(
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       ce,
	// bus handshake
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// octet stream
	input wire logic       octet_valid,
	input wire logic [7:0] octet_data,
	input wire logic       octet_last,
	input wire logic       octet_ready
);
	logic [3:0] oct_idx;
	logic [3:0] next_oct_idx;
	logic       take;
	assign take = octet_valid && octet_ready && ce;
	// position of the octet on offer, so field checks know which octet they see
	always_comb begin
		next_oct_idx = oct_idx;
		if (take)
			next_oct_idx = octet_last ? 4'h0 : oct_idx + 4'h1;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			oct_idx <= 4'h0;
		else
			oct_idx <= next_oct_idx;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_BUS_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
		else $error("bus request not answered in the next cycle");
	AST_BUS_ACK_PULSE: assert property (wb_ack_o && ce |=> !wb_ack_o)
		else $error("bus acknowledge longer than one cycle");
	AST_FIRST_ID: assert property (octet_valid && oct_idx == 4'h0 |-> octet_data == MSG_ID_NET || octet_data == MSG_ID_CUST)
		else $error("first octet is not a status message identifier");
	AST_OCT2_RESERVED: assert property (octet_valid && oct_idx == 4'h1 |-> octet_data[7] == 1'b0 && octet_data[0] == 1'b0)
		else $error("reserved bits of octet 2 not zero");
	AST_OCT12_FIELDS: assert property (octet_valid && oct_idx == 4'hB |-> octet_data[6:2] == 5'h00 && octet_data[1:0] inside {2'h1, 2'h2})
		else $error("octet 12 reserved bits or loop identifier wrong");
	AST_TWELVE_OCTETS: assert property (octet_valid |-> octet_last == (oct_idx == 4'hB))
		else $error("last marker not on octet 12");
	AST_OCTET_HOLD: assert property (octet_valid && !octet_ready |=> octet_valid && $stable(octet_data) && $stable(octet_last))
		else $error("offered octet changed before acceptance");
	AST_NEXT_OCTET: assert property (take && !octet_last |=> octet_valid)
		else $error("next octet not offered in the following cycle");
	AST_IDLE_AFTER_LAST: assert property (take && octet_last |=> !octet_valid ##1 !octet_valid)
		else $error("stream not idle after the last octet");
endmodule
bind line_performance_status_builder line_performance_status_builder_properties u_props (.clk_sys(clk_sys), .rst(rst),
	.ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .octet_valid(octet_valid),
	.octet_data(octet_data), .octet_last(octet_last), .octet_ready(octet_ready));

// ### octet_sink.sv
// stream sink standing for the management unit that collects status octets
`timescale 1ns/1ps
module octet_sink (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// octet stream
	input  wire logic       octet_valid,
	input  wire logic [7:0] octet_data,
	input  wire logic       octet_last,
	output logic            octet_ready,
	// random back-pressure when high
	input  wire logic       stall_en
);
	logic [7:0] got[$];
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			octet_ready <= 1'b0;
		else
			octet_ready <= stall_en ? 1'($urandom_range(0, 1)) : 1'b1;
	end
	always @(posedge clk_sys) begin
		if (!rst && octet_valid && octet_ready)
			got.push_back(octet_data);
	end
endmodule

// ### line_performance_status_builder_tb_top.sv
// self-checking bench for the performance status message builder
`timescale 1ns/1ps
module line_performance_status_builder_tb_top
	import perf_status_pkg::*;
;
	logic        clk_sys, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [7:0]  wb_adr_i, octet_data;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        self_test_fault, dc_continuity_fault, octet_valid, octet_last, octet_ready, stall_en;
	logic [1:0]  errsec_tick, sevsec_tick, crc_tick, syncloss_tick, unavsec_tick, flt;
	int          miscompares, n_compared;
	int          cnt[2][5];
	logic [3:0]  flg[2];
	logic [31:0] cfg[2];
	logic [2:0]  istat;

	line_performance_status_builder u_line_performance_status_builder (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .self_test_fault(self_test_fault),
		.dc_continuity_fault(dc_continuity_fault), .errsec_tick(errsec_tick), .sevsec_tick(sevsec_tick),
		.crc_tick(crc_tick), .syncloss_tick(syncloss_tick), .unavsec_tick(unavsec_tick),
		.octet_valid(octet_valid), .octet_data(octet_data), .octet_last(octet_last),
		.octet_ready(octet_ready), .irq(irq));
	octet_sink u_octet_sink (.clk_sys(clk_sys), .rst(rst), .octet_valid(octet_valid), .octet_data(octet_data),
		.octet_last(octet_last), .octet_ready(octet_ready), .stall_en(stall_en));

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		end_sim();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one classic cycle, entered just after a rising edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) hang();
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_sys);
	endtask
	function automatic void bump(int s, int k);
		cnt[s][k] = (cnt[s][k] + 1) % (k == 2 ? 65536 : 256);
		if (cnt[s][k] == 0) begin
			flg[s] |= 4'hA;
			istat[1 + s] = 1'b1;
		end
	endfunction
	// event pulses, kept one cycle apart so each is a clean single pulse
	task automatic ticks(int cycles, logic [9:0] force_on);
		logic [9:0] v;
		repeat (cycles) begin
			v = 10'($urandom) | force_on;
			{errsec_tick, sevsec_tick, crc_tick, syncloss_tick, unavsec_tick} <= v;
			@(posedge clk_sys);
			{errsec_tick, sevsec_tick, crc_tick, syncloss_tick, unavsec_tick} <= 10'h000;
			for (int s = 0; s < 2; s++)
				for (int k = 0; k < 5; k++)
					if (v[8 - 2 * k + s]) bump(s, k);
			@(posedge clk_sys);
		end
	endtask
	task automatic setup(int s);
		logic [31:0] q;
		cfg[s] = ($urandom & 32'h01FF_FFFF) | (32'($urandom_range(1, 2)) << SIDE_LOOP_LSB);
		wb(1'b1, s ? ADDR_SIDE_CUST : ADDR_SIDE_NET, cfg[s], q);
	endtask
	task automatic send(int s, int d);
		logic [95:0] exp, got;
		logic [31:0] q, c;
		int n;
		c = cfg[s];
		exp = {s ? MSG_ID_CUST : MSG_ID_NET, 1'b0, c[SIDE_BACKOFF], flt, c[SIDE_MARGIN_AL], c[SIDE_ATTEN_AL],
			c[SIDE_SYNC_AL], 1'b0, c[7:0], c[15:8], 8'(cnt[s][0]), 8'(cnt[s][1]), 16'(cnt[s][2]),
			8'(cnt[s][3]), 8'(cnt[s][4]), flg[s], c[19:16], c[20], 5'h00, c[26:25]};
		u_octet_sink.got.delete();
		wb(1'b1, ADDR_CTRL, 32'(d * 4 + s * 2 + 1), q);
		for (n = 0; n < 400 && u_octet_sink.got.size() < 12; n++) @(posedge clk_sys);
		if (n >= 400) hang();
		for (int k = 0; k < 12; k++) got[95 - 8 * k -: 8] = u_octet_sink.got[k];
		chk(got[95:64], exp[95:64]);
		chk(got[63:32], exp[63:32]);
		chk(got[31:0], exp[31:0]);
		flg[s] &= d ? 4'hC : 4'h3;
		istat[0] = 1'b1;
		for (n = 0; n < 20; n++) begin
			wb(1'b0, ADDR_CTRL, 32'h0, q);
			if (q[CTRL_BUSY] === 1'b0)
				break;
		end
		if (n >= 20) hang();
		wb(1'b0, ADDR_FLAGS, 32'h0, q);
		chk(q, {24'h0, flg[1], flg[0]});
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		logic [31:0] q;
		void'($urandom(32757));
		rst = 1'b1;
		ce = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h0;
		wb_sel_i = 4'hF;
		{self_test_fault, dc_continuity_fault, stall_en, flt, istat} = 8'h00;
		{errsec_tick, sevsec_tick, crc_tick, syncloss_tick, unavsec_tick} = 10'h000;
		miscompares = 0;
		n_compared = 0;
		cnt = '{default: 0};
		flg = '{4'h5, 4'h5};
		cfg = '{SIDE_RESET, SIDE_RESET};
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		wb(1'b0, ADDR_SIDE_NET, 32'h0, q);
		chk(q, SIDE_RESET);
		wb(1'b0, ADDR_FLAGS, 32'h0, q);
		chk(q, 32'h55);
		wb(1'b1, 8'hFC, 32'hFFFF_FFFF, q);
		wb(1'b0, 8'hFC, 32'h0, q);
		chk(q, 32'h0);
		send(0, 0);
		for (int i = 0; i < 4; i++) begin
			stall_en <= i[0];
			flt = 2'($urandom);
			{self_test_fault, dc_continuity_fault} <= flt;
			setup(0);
			setup(1);
			ticks(30, 10'h000);
			send(i % 2, i / 2);
		end
		// errored seconds run past 255 on both sides
		ticks(260, 10'h300);
		wb(1'b0, ADDR_CNT_CUST, 32'h0, q);
		chk(q, {8'(cnt[1][4]), 8'(cnt[1][3]), 8'(cnt[1][1]), 8'(cnt[1][0])});
		wb(1'b0, ADDR_CRC_NET, 32'h0, q);
		chk(q, 32'(cnt[0][2]));
		send(0, 1);
		send(1, 0);
		wb(1'b1, ADDR_CTRL, 32'h300, q);
		cnt = '{default: 0};
		flg[0] |= 4'h5;
		flg[1] |= 4'h5;
		send(1, 1);
		wb(1'b0, ADDR_CNT_NET, 32'h0, q);
		chk(q, 32'h0);
		// enable low: event pulses are ignored, nothing counts
		ce <= 1'b0;
		{errsec_tick, sevsec_tick, crc_tick, syncloss_tick, unavsec_tick} <= 10'h3FF;
		@(posedge clk_sys);
		{errsec_tick, sevsec_tick, crc_tick, syncloss_tick, unavsec_tick} <= 10'h000;
		@(posedge clk_sys);
		ce <= 1'b1;
		@(posedge clk_sys);
		wb(1'b0, ADDR_CNT_NET, 32'h0, q);
		chk(q, {8'(cnt[0][4]), 8'(cnt[0][3]), 8'(cnt[0][1]), 8'(cnt[0][0])});
		wb(1'b1, ADDR_IRQ_MASK, 32'h0, q);
		wb(1'b0, ADDR_IRQ_STAT, 32'h0, q);
		chk(q, {29'h0, istat});
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, ADDR_IRQ_STAT, 32'h7, q);
		wb(1'b1, ADDR_IRQ_MASK, 32'h1, q);
		chk({31'h0, irq}, 32'h0);
		send(0, 0);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, ADDR_IRQ_STAT, 32'h1, q);
		@(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		end_sim();
	end
endmodule
